// file: design/wdc_defines.svh
// Register offsets, field positions and timing counts for the watchdog control block
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH
`define WDC_CTRL_ADDR 8'h00
`define WDC_CFG_ADDR 8'h04
`define WDC_STAT_ADDR 8'h08
`define WDC_CNT_ADDR 8'h0c
`define WDC_ENABLE_BIT 15
`define WDC_PS_HI 6
`define WDC_PS_LO 2
`define WDC_WIN_BIT 1
`define WDC_SERVICE_BIT 0
`define WDC_TICK_NS 1000
`define WDC_CLK_NS 50
`define WDC_TICK_CYCLES ((`WDC_TICK_NS + `WDC_CLK_NS - 1) / `WDC_CLK_NS)
`endif

// file: design/wdc_pkg.sv
// Types shared by the watchdog control block
package wdc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wdc_bus_t;
  typedef struct packed {
    logic fuse_enable;
    logic [4:0] postscaler_fuses;
  } wdc_cfg_t;
  typedef enum logic [1:0] {WDC_OFF, WDC_RUN, WDC_EXPIRED} wdc_state_t;
endpackage

// file: design/wdc_tick.sv
// Prescaler that turns mclk into a slow watchdog tick
`timescale 1ns/100ps
module wdc_tick #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  output logic tick
);
  localparam int W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  logic [W-1:0] div;
  // A zero-length tick period has no meaning for the divider
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("wdc_tick: TICK_CYCLES must be at least 1");
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !run)
    begin
      div <= '0;
      tick <= 1'b0;
    end
    else if (div == W'(TICK_CYCLES - 1))
    begin
      div <= '0;
      tick <= 1'b1;
    end
    else
    begin
      div <= div + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// file: design/wdc_top.sv
// Watchdog control register with fuse-or-software enable, window mode, service and timeout
//
// Contract
// [RULE1] Writing one to bit 15 starts the watchdog unless fuses already enabled it.
// [RULE2] Writing zero to bit 15 stops only a software-started watchdog.
// [RULE3] Bit 15 reads one whenever the watchdog runs, fuse or software.
// [RULE4] Bits 6..2 are read-only, reloaded from postscaler fuses at each reset.
// [RULE5] Bit 1 selects windowed operation; zero selects ordinary operation.
// [RULE6] Writing one to bit 0 clears the watchdog counter.
// [RULE7] Writing zero to bit 0 does nothing.
// [RULE8] Bits 31..16 and 14..7 ignore writes and read zero.
// [RULE9] Software avoids register access the cycle after clearing the enable bit.
// [RULE10] Unserviced counter reaching the postscaler timeout raises a reset request.
`timescale 1ns/100ps
`include "wdc_defines.svh"
module wdc_top #(
  parameter int TICK_CYCLES = `WDC_TICK_CYCLES,
  parameter int CNT_W = 32
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire wdc_pkg::wdc_bus_t bus,
  input wire wdc_pkg::wdc_cfg_t cfg,
  output logic [31:0] rdata,
  output logic running,
  output logic window_mode,
  output logic timeout_reset,
  output logic window_violation
);
  // Counter width has to fit the 32-bit read path
  if (CNT_W < 17 || CNT_W > 32)
  begin : g_bad_cnt_w
    $error("wdc_top: CNT_W must lie in 17..32");
  end

  logic sw_enable;
  logic fuse_enable;
  logic [4:0] postscaler_shadow;
  logic window_enable;
  logic [CNT_W-1:0] watchdog_counter;
  logic service;
  logic tick;
  logic expired;
  logic win_err;
  wdc_pkg::wdc_state_t state;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Timeout in ticks is 2^postscaler, capped by counter width
  function automatic logic [CNT_W-1:0] limit(input logic [4:0] ps);
    limit = (ps >= 5'(CNT_W - 1)) ? {1'b0, {(CNT_W-1){1'b1}}} : CNT_W'(1) << ps;
  endfunction

  wire wr_ctrl = bus.wr && hit(bus.addr, `WDC_CTRL_ADDR);
  wire run_now = fuse_enable || sw_enable; // [RULE3]

  // Fuses and shadow are caught by a clocked process while reset is held
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      fuse_enable <= cfg.fuse_enable;
      postscaler_shadow <= cfg.postscaler_fuses; // [RULE4]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sw_enable <= 1'b0;
    else if (wr_ctrl)
      sw_enable <= bus.wdata[`WDC_ENABLE_BIT]; // [RULE1] [RULE2] fuse enable keeps it running regardless
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      window_enable <= 1'b0;
    else if (wr_ctrl)
      window_enable <= bus.wdata[`WDC_WIN_BIT]; // [RULE5]
  end

  // Service bit is write-one only and never stored, so it always reads zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      service <= 1'b0;
    else
      service <= wr_ctrl && bus.wdata[`WDC_SERVICE_BIT]; // [RULE6] [RULE7]
  end

  wdc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(running),
    .tick(tick)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= wdc_pkg::WDC_OFF;
      watchdog_counter <= '0;
      expired <= 1'b0;
      win_err <= 1'b0;
    end
    else
    begin
      unique case (state)
        wdc_pkg::WDC_OFF:
        begin
          watchdog_counter <= '0;
          if (run_now)
            state <= wdc_pkg::WDC_RUN;
        end
        wdc_pkg::WDC_RUN:
        begin
          if (!run_now)
          begin
            state <= wdc_pkg::WDC_OFF;
            watchdog_counter <= '0;
          end
          else if (service)
          begin
            // Servicing in the first half of the period in window mode is a violation
            if (window_enable && watchdog_counter < (limit(postscaler_shadow) >> 1))
            begin
              win_err <= 1'b1;
              state <= wdc_pkg::WDC_EXPIRED;
            end
            watchdog_counter <= '0; // [RULE6]
          end
          else if (tick)
          begin
            if (watchdog_counter + 1'b1 >= limit(postscaler_shadow))
            begin
              expired <= 1'b1; // [RULE10]
              state <= wdc_pkg::WDC_EXPIRED;
            end
            watchdog_counter <= watchdog_counter + 1'b1;
          end
        end
        wdc_pkg::WDC_EXPIRED:
        begin
          // Held until a system reset; the request must not drop by itself
          state <= wdc_pkg::WDC_EXPIRED;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      running <= 1'b0;
      window_mode <= 1'b0;
      timeout_reset <= 1'b0;
      window_violation <= 1'b0;
    end
    else
    begin
      running <= run_now && state != wdc_pkg::WDC_EXPIRED;
      window_mode <= window_enable;
      timeout_reset <= expired || win_err; // [RULE10]
      window_violation <= win_err;
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata <= 32'h0000_0000;
    else if (!bus.rd)
      rdata <= 32'h0000_0000;
    else if (hit(bus.addr, `WDC_CTRL_ADDR))
      rdata <= {16'h0000, run_now, 8'h00, postscaler_shadow, window_enable, 1'b0}; // [RULE3] [RULE8]
    else if (hit(bus.addr, `WDC_STAT_ADDR))
      rdata <= {29'h0, win_err, expired, fuse_enable};
    else if (hit(bus.addr, `WDC_CNT_ADDR))
      rdata <= 32'(watchdog_counter);
    else
      rdata <= 32'h0000_0000;
  end

  a_fuse_keeps_run: assert property (@(posedge mclk) disable iff (sys_rst)
    (fuse_enable && bus.rd && hit(bus.addr, `WDC_CTRL_ADDR)) |=> rdata[`WDC_ENABLE_BIT])
    else $error("Fuse-enabled watchdog read as stopped"); // [RULE2]
  a_sw_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_ctrl && bus.wdata[`WDC_ENABLE_BIT]) |=> sw_enable)
    else $error("Software enable not taken"); // [RULE1]
  a_read_enable: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rd && hit(bus.addr, `WDC_CTRL_ADDR)) |=> rdata[`WDC_ENABLE_BIT] == $past(run_now))
    else $error("Enable bit read mismatch"); // [RULE3]
  a_shadow_stable: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus.rd && hit(bus.addr, `WDC_CTRL_ADDR)) |=>
    rdata[`WDC_PS_HI:`WDC_PS_LO] == $past(postscaler_shadow) && $stable(postscaler_shadow))
    else $error("Postscaler shadow changed outside reset"); // [RULE4]
  a_window_bit: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_ctrl |=> ##1 window_mode == $past(bus.wdata[`WDC_WIN_BIT], 2))
    else $error("Window mode not following write"); // [RULE5]
  a_service_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    (service && state == wdc_pkg::WDC_RUN && run_now) |=> watchdog_counter == '0)
    else $error("Service did not clear counter"); // [RULE6]
  a_zero_no_service: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_ctrl && !bus.wdata[`WDC_SERVICE_BIT]) |=> !service)
    else $error("Writing zero serviced the watchdog"); // [RULE7]
  a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    rdata[31:16] == 16'h0000 && rdata[14:7] == 8'h00 || !$past(hit(bus.addr, `WDC_CTRL_ADDR)))
    else $error("Reserved bits read nonzero"); // [RULE8]
  a_timeout_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    expired |=> timeout_reset [*3])
    else $error("Timeout request not held"); // [RULE10]

  c_sw_start: cover property (@(posedge mclk) disable iff (sys_rst) !running ##1 running);
  c_timeout: cover property (@(posedge mclk) disable iff (sys_rst) $rose(timeout_reset));
  c_window_err: cover property (@(posedge mclk) disable iff (sys_rst) $rose(window_violation));
  c_service: cover property (@(posedge mclk) disable iff (sys_rst) service && running);
endmodule

// file: verification/test_watchdog_control_register.sv
// Self-checking bench for the watchdog control register block
`timescale 1ns/100ps
module test_watchdog_control_register;
  logic mclk;
  logic sys_rst;
  wdc_pkg::wdc_bus_t bus;
  wdc_pkg::wdc_cfg_t cfg;
  logic [31:0] rdata;
  logic running;
  logic window_mode;
  logic timeout_reset;
  logic window_violation;
  int err_count;
  int n_tests;
  int seed;
  int i;
  logic [31:0] d;
  logic [31:0] w;
  logic [4:0] ps;

  // One-cycle tick keeps timeout runs short
  wdc_top #(.TICK_CYCLES(1)) dut_u (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .bus(bus),
    .cfg(cfg),
    .rdata(rdata),
    .running(running),
    .window_mode(window_mode),
    .timeout_reset(timeout_reset),
    .window_violation(window_violation)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] exp_ctrl(logic run, logic [4:0] p, logic win);
    return {16'h0000, run, 8'h00, p, win, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // A write shows on the level outputs one edge after it is taken; settle waits two edges
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic rst_dut(input logic fe, input logic [4:0] p);
    @(posedge mclk);
    sys_rst <= 1'b1;
    cfg <= {fe, p};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    bus = '0;
    cfg = '0;
    seed = 82;
    for (i = 0; i < 3; i++)
    begin
      ps = 5'($random(seed));
      rst_dut(1'b0, ps);
      rd(8'h00, d);
      chk(d, exp_ctrl(1'b0, ps, 1'b0));
      w = $random(seed);
      wr(8'h00, w | 32'h0000_8002);
      settle();
      chk({31'h0, running}, 32'h1);
      chk({31'h0, window_mode}, 32'h1);
      rd(8'h00, d);
      chk(d, exp_ctrl(1'b1, ps, 1'b1));
      wr(8'h00, 32'h0000_0000);
      settle();
      chk({31'h0, running}, 32'h0);
      chk({31'h0, window_mode}, 32'h0);
      rd(8'h04, d);
      chk(d, 32'h0);
    end
    $display("software enable test done");
    rst_dut(1'b1, 5'h1f);
    rd(8'h00, d);
    chk(d, exp_ctrl(1'b1, 5'h1f, 1'b0));
    wr(8'h00, 32'h0000_0000);
    settle();
    chk({31'h0, running}, 32'h1);
    rd(8'h00, d);
    chk(d, exp_ctrl(1'b1, 5'h1f, 1'b0));
    $display("fuse enable test done");
    rst_dut(1'b0, 5'h04);
    wr(8'h00, 32'h0000_8000);
    for (i = 0; i < 12; i++)
      wr(8'h00, 32'h0000_8001);
    #1;
    chk({31'h0, timeout_reset}, 32'h0);
    chk({31'h0, window_violation}, 32'h0);
    // Zero in the service bit must not hold off the timeout
    for (i = 0; i < 12; i++)
      wr(8'h00, 32'h0000_8000);
    #1;
    chk({31'h0, timeout_reset}, 32'h1);
    // Status shows expired only; the counter froze at 2^4 ticks
    rd(8'h08, d);
    chk(d, 32'h0000_0002);
    rd(8'h0c, d);
    chk(d, 32'h0000_0010);
    $display("service and timeout test done");
    rst_dut(1'b0, 5'h04);
    wr(8'h00, 32'h0000_8002);
    wr(8'h00, 32'h0000_8003);
    i = 0;
    while (window_violation !== 1'b1 && i < 100)
    begin
      @(posedge mclk);
      i++;
    end
    if (i == 100)
      err_count++;
    chk({31'h0, window_violation}, 32'h1);
    chk({31'h0, timeout_reset}, 32'h1);
    rd(8'h08, d);
    chk(d, 32'h0000_0004);
    $display("window test done");
    stop_test();
  end
endmodule
